// file: src/psw_pkg.sv
// Purpose: Shared constants and types for the status word and address wrap logic.
// Assumes: 32-bit data path, 24-bit physical address space.
// Notes:   Field positions follow the status word layout.
package psw_pkg;

  localparam int          PSW_W            = 32;           // Status word width.
  localparam int          RFU_LO           = 8;            // Lowest reserved bit.
  localparam int          NP_BIT           = 7;            // NMI in service.
  localparam int          EP_BIT           = 6;            // Exception in progress.
  localparam int          ID_BIT           = 5;            // Maskable interrupts disabled.
  localparam int          SAT_BIT          = 4;            // Sticky saturation.
  localparam int          CY_BIT           = 3;            // Carry or borrow.
  localparam int          OV_BIT           = 2;            // Signed overflow.
  localparam int          S_BIT            = 1;            // Negative result.
  localparam int          Z_BIT            = 0;            // Zero result.
  localparam logic [31:0] PSW_RESET        = 32'h0000_0020; // Status word after reset.
  localparam logic [31:0] SAT_POS_MAX      = 32'h7FFF_FFFF; // Largest positive value.
  localparam logic [31:0] SAT_NEG_MIN      = 32'h8000_0000; // Most negative value.
  localparam logic [31:0] RESET_ENTRY_ADDR = 32'h0000_0000; // Reset fetch address in ROM.
  localparam logic [31:0] PC_VALID_MASK    = 32'h00FF_FFFE; // Live program counter bits.
  localparam int          PHYS_ADDR_W      = 24;           // Physical address width.

  // Arithmetic operations; bit 0 selects subtract, bit 1 selects saturation.
  typedef enum logic [1:0]
  {
    OP_ADD    = 2'b00,
    OP_SUB    = 2'b01,
    OP_SATADD = 2'b10,
    OP_SATSUB = 2'b11
  } alu_op_t;

endpackage : psw_pkg

// file: src/arith_if.sv
// Purpose: Carries operands and flag results between the core and the flag unit.
// Assumes: Purely combinational path inside one clock cycle.
// Notes:   The core drives operands, the unit answers with result and flags.
`timescale 1ns/100ps
interface arith_if;
  import psw_pkg::*;
  logic [31:0] a;       // First operand.
  logic [31:0] b;       // Second operand.
  alu_op_t     op;      // Operation.
  logic [31:0] result;  // Final, possibly saturated, result.
  logic        cy;      // Carry or borrow out of bit 31.
  logic        ov;      // Signed overflow.
  logic        s;       // Result negative.
  logic        z;       // Result zero.
  logic        sat_hit; // Saturating operation overflowed.
  modport core (output a, b, op, input result, cy, ov, s, z, sat_hit);
  modport unit (input a, b, op, output result, cy, ov, s, z, sat_hit);
endinterface : arith_if

// file: src/arith_flag_unit.sv
// Purpose: Adds or subtracts, saturates when asked, and derives the result flags.
// Assumes: Operands are stable for the whole cycle.
// Notes:   No state; the core registers everything it produces.
`timescale 1ns/100ps
module arith_flag_unit
(
  arith_if.unit port_u
);
  import psw_pkg::*;

  logic [32:0] wide;   // Sum or difference with carry bit.
  logic [31:0] raw;    // Unsaturated result.
  logic        is_sub; // Subtract select.
  logic        is_sat; // Saturation select.
  logic        ovf;    // Signed overflow of the raw result.

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic, saturation and flag derivation.
  always_comb
  begin
    is_sub = port_u.op[0];
    is_sat = port_u.op[1];
    // Bit 32 is carry on add and borrow on subtract.
    wide = is_sub ? ({1'b0, port_u.a} - {1'b0, port_u.b})
                  : ({1'b0, port_u.a} + {1'b0, port_u.b});
    raw  = wide[31:0];
    ovf  = is_sub ? ((port_u.a[31] != port_u.b[31]) && (raw[31] != port_u.a[31]))
                  : ((port_u.a[31] == port_u.b[31]) && (raw[31] != port_u.a[31]));
    // The overflow direction follows the first operand's sign.
    port_u.result = raw; // RL9
    if (is_sat && ovf)
    begin
      port_u.result = port_u.a[31] ? SAT_NEG_MIN : SAT_POS_MAX; // RL6
    end
    port_u.cy      = wide[32];                   // RL10
    port_u.ov      = ovf;                        // RL11
    port_u.s       = port_u.result[31];          // RL12
    port_u.z       = (port_u.result == 32'h0000_0000); // RL13
    port_u.sat_hit = is_sat && ovf;              // RL6
  end

endmodule : arith_flag_unit

// file: src/cpu_status_flags_and_address_wrap.sv
// Purpose: Status word, saturating result flags, interrupt state bits and address wrap.
// Assumes: One core clock; all inputs come from pipeline logic on that clock.
// Notes:   Hardware set events win over a same-cycle status word write.
`timescale 1ns/100ps
//
// Contract
// RL1: Status word bits 31..8 always read zero.
// RL2: NMI acknowledge sets bit 7; blocks nesting.
// RL3: Exception sets bit 6; interrupts still accepted.
// RL4: Bit 5 gates maskables; set on acknowledge.
// RL5: Saturation bit sticky until status word write.
// RL6: Saturated result from overflow and sign.
// RL7: Positive overflow gives max, flags 1,1,0.
// RL8: Negative overflow gives min, flags 1,1,1.
// RL9: In range: raw result, overflow clear, saturation kept.
// RL10: Bit 3 records carry or borrow.
// RL11: Bit 2 records signed overflow.
// RL12: Bit 1 set for negative result.
// RL13: Bit 0 set for zero result.
// RL14: After reset: port mode, fetch reset entry.
// RL15: Software enables expansion; off after reset.
// RL16: Upper eight address bits ignored physically.
// RL17: Program counter bits 31..24 stay zero.
// RL18: Software never branches into peripheral region.
// RL19: Operand address carry beyond 32 dropped.
// RL20: Program counter bit 0 held zero.
// RL21: Flags update at writeback, else held.
module cpu_status_flags_and_address_wrap
(
  input  wire logic                 clock,
  input  wire logic                 resetn,
  input  wire logic                 psw_wr_en,
  input  wire logic [31:0]          psw_wr_data,
  output logic [31:0]               program_status_word,
  input  wire logic                 alu_wb_valid,
  input  wire logic                 alu_sets_flags,
  input  wire psw_pkg::alu_op_t     alu_op,
  input  wire logic [31:0]          alu_a,
  input  wire logic [31:0]          alu_b,
  output logic [31:0]               alu_result,
  input  wire logic                 nmi_ack,
  input  wire logic                 exception_gen,
  input  wire logic                 maskable_irq_req,
  output logic                      maskable_irq_grant,
  input  wire logic                 pc_load_en,
  input  wire logic [31:0]          pc_target,
  input  wire logic                 pc_step_en,
  input  wire logic [31:0]          pc_offset,
  output logic [31:0]               program_counter,
  input  wire logic                 opnd_valid,
  input  wire logic [31:0]          opnd_base,
  input  wire logic [31:0]          opnd_disp,
  output logic [31:0]               data_addr,
  output logic [23:0]               data_phys_addr,
  input  wire logic                 mem_exp_wr_en,
  input  wire logic                 mem_exp_enable_in,
  output logic                      ext_expansion_en,
  output logic                      bus_port_mode
);
  import psw_pkg::*;

  // Whole block state in one word; the flags byte mirrors status word bits 7..0.
  typedef struct packed
  {
    logic [7:0]  flags;  // Status word bits 7..0.
    logic [23:0] pc;     // Live program counter bits.
    logic [31:0] daddr;  // Wrapped operand address.
    logic [31:0] result; // Written-back result.
    logic        expn;   // External expansion enabled.
  } core_state_t;

  core_state_t st_r;   // Registered state.
  core_state_t st_nxt; // Next state.

  arith_if sif ();     // Path to the flag unit.

  ////////////////////////////////////////////////////////////////////////////
  // Keeps only the live program counter bits, so a carry past bit 23 and an
  // odd target both vanish; used for loads and for relative steps.
  function automatic logic [23:0] pc_wrap(input logic [31:0] addr);
    pc_wrap = addr[23:0] & PC_VALID_MASK[23:0]; // RL17 RL20
  endfunction : pc_wrap

  ////////////////////////////////////////////////////////////////////////////
  // Flag unit.
  assign sif.a  = alu_a;
  assign sif.b  = alu_b;
  assign sif.op = alu_op;

  arith_flag_unit u_flags
  (
    .port_u (sif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Maskable acceptance; exception state deliberately does not block it.
  always_comb
  begin
    maskable_irq_grant = maskable_irq_req && !st_r.flags[ID_BIT] // RL4
                         && !st_r.flags[NP_BIT];                 // RL2 RL3
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic. Order matters: a software write lands first, then the
  // hardware events, so an event in the same cycle as a write is never lost.
  always_comb
  begin
    st_nxt = st_r;
    // Direct write; only bits 7..0 exist, the rest are dropped.
    if (psw_wr_en)
    begin
      st_nxt.flags = psw_wr_data[7:0]; // RL1 RL5
    end
    // Writeback of an arithmetic result.
    if (alu_wb_valid)
    begin
      st_nxt.result = sif.result;
      // Non-flag instructions leave the flags alone.
      if (alu_sets_flags)
      begin
        st_nxt.flags[CY_BIT] = sif.cy; // RL10 RL21
        st_nxt.flags[OV_BIT] = sif.ov; // RL11 RL7 RL8 RL9
        st_nxt.flags[S_BIT]  = sif.s;  // RL12
        st_nxt.flags[Z_BIT]  = sif.z;  // RL13
        // Saturation only ever sets here; in-range results keep it.
        if (sif.sat_hit)
        begin
          st_nxt.flags[SAT_BIT] = 1'b1; // RL5 RL6
        end
      end
    end
    // Interrupt and exception state bits.
    if (nmi_ack)
    begin
      st_nxt.flags[NP_BIT] = 1'b1; // RL2
    end
    if (maskable_irq_grant)
    begin
      st_nxt.flags[ID_BIT] = 1'b1; // RL4
    end
    if (exception_gen)
    begin
      st_nxt.flags[EP_BIT] = 1'b1; // RL3
    end
    // Program counter: a load beats a relative step.
    if (pc_load_en)
    begin
      st_nxt.pc = pc_wrap(pc_target); // RL17
    end
    else if (pc_step_en)
    begin
      st_nxt.pc = pc_wrap({8'h00, st_r.pc} + pc_offset); // RL17
    end
    // Operand address: the 32-bit sum simply drops its carry.
    if (opnd_valid)
    begin
      st_nxt.daddr = opnd_base + opnd_disp; // RL19
    end
    // Expansion mode is only ever turned on by software.
    if (mem_exp_wr_en)
    begin
      st_nxt.expn = mem_exp_enable_in; // RL15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset starts fetch at the entry address in port mode.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r.flags  <= PSW_RESET[7:0];
      st_r.pc     <= RESET_ENTRY_ADDR[23:0]; // RL14
      st_r.daddr  <= 32'h0000_0000;
      st_r.result <= 32'h0000_0000;
      st_r.expn   <= 1'b0;                   // RL14 RL15
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all taken from the state register.
  assign program_status_word = {24'h00_0000, st_r.flags};     // RL1
  assign program_counter     = {8'h00, st_r.pc};              // RL17
  assign alu_result          = st_r.result;
  assign data_addr           = st_r.daddr;
  assign data_phys_addr      = st_r.daddr[PHYS_ADDR_W-1:0];   // RL16
  assign ext_expansion_en    = st_r.expn;
  assign bus_port_mode       = !st_r.expn;                    // RL14

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  AST_RFU_ZERO: assert property (@(posedge clock) disable iff (!resetn) // RL1
    psw_wr_en |=> program_status_word[31:8] == 24'h00_0000)
    else $error("Reserved status bits not zero after write.");

  AST_NP_SET: assert property (@(posedge clock) disable iff (!resetn) // RL2
    nmi_ack |=> program_status_word[NP_BIT] && !maskable_irq_grant)
    else $error("NMI acknowledge did not set and block.");

  AST_EP_OPEN: assert property (@(posedge clock) disable iff (!resetn) // RL3
    exception_gen && !st_r.flags[ID_BIT] && !st_r.flags[NP_BIT] && !nmi_ack
    && !maskable_irq_grant && !psw_wr_en
    |=> program_status_word[EP_BIT] && (maskable_irq_req == maskable_irq_grant))
    else $error("Exception state wrong or blocked interrupts.");

  AST_ID_GATE: assert property (@(posedge clock) disable iff (!resetn) // RL4
    maskable_irq_grant |=> program_status_word[ID_BIT] && !maskable_irq_grant)
    else $error("Maskable grant did not set disable flag.");

  AST_SAT_STICKY: assert property (@(posedge clock) disable iff (!resetn) // RL5
    program_status_word[SAT_BIT] && !psw_wr_en |=> program_status_word[SAT_BIT])
    else $error("Saturation flag dropped without write.");

  AST_SAT_POS: assert property (@(posedge clock) disable iff (!resetn) // RL7
    alu_wb_valid && alu_sets_flags && alu_op[1] && sif.ov && !alu_a[31]
    |=> alu_result == SAT_POS_MAX && program_status_word[SAT_BIT]
        && program_status_word[OV_BIT] && !program_status_word[S_BIT])
    else $error("Positive saturation wrong.");

  AST_SAT_NEG: assert property (@(posedge clock) disable iff (!resetn) // RL8
    alu_wb_valid && alu_sets_flags && alu_op[1] && sif.ov && alu_a[31]
    |=> alu_result == SAT_NEG_MIN && program_status_word[SAT_BIT]
        && program_status_word[OV_BIT] && program_status_word[S_BIT])
    else $error("Negative saturation wrong.");

  AST_SAT_RANGE: assert property (@(posedge clock) disable iff (!resetn) // RL9
    alu_wb_valid && alu_sets_flags && alu_op[1] && !sif.ov && !psw_wr_en
    |=> !program_status_word[OV_BIT]
        && program_status_word[S_BIT] == alu_result[31]
        && program_status_word[SAT_BIT] == $past(program_status_word[SAT_BIT]))
    else $error("In-range saturating result handled wrongly.");

  AST_ZERO_SIGN: assert property (@(posedge clock) disable iff (!resetn) // RL12 RL13
    alu_wb_valid && alu_sets_flags
    |=> program_status_word[Z_BIT] == (alu_result == 32'h0000_0000)
        && program_status_word[S_BIT] == alu_result[31])
    else $error("Zero or sign flag disagrees with result.");

  AST_FLAG_HOLD: assert property (@(posedge clock) disable iff (!resetn) // RL21
    !(alu_wb_valid && alu_sets_flags) && !psw_wr_en
    |=> program_status_word[3:0] == $past(program_status_word[3:0]))
    else $error("Result flags changed without writeback.");

  AST_PC_WRAP: assert property (@(posedge clock) disable iff (!resetn) // RL17 RL20
    pc_step_en && !pc_load_en
    |=> program_counter == (($past(program_counter) + $past(pc_offset)) & PC_VALID_MASK))
    else $error("Program counter did not wrap.");

  AST_DATA_WRAP: assert property (@(posedge clock) disable iff (!resetn) // RL16 RL19
    opnd_valid |=> data_addr == $past(opnd_base) + $past(opnd_disp)
                   && data_phys_addr == data_addr[23:0])
    else $error("Operand address not wrapped.");

  AST_PORT_MODE: assert property (@(posedge clock) disable iff (!resetn) // RL14
    !mem_exp_wr_en
    |=> ext_expansion_en == $past(ext_expansion_en) && bus_port_mode == !ext_expansion_en)
    else $error("Left port mode without software write.");

  // Expansion follows the software write, and port mode is always its inverse.
  AST_EXP_WRITE: assert property (@(posedge clock) disable iff (!resetn) // RL14 RL15
    mem_exp_wr_en |=> ext_expansion_en == $past(mem_exp_enable_in)
                      && bus_port_mode == !ext_expansion_en)
    else $error("Expansion enable did not follow its write.");

  // An add carries out exactly when the wrapped sum falls below the first operand.
  AST_CY_CARRY: assert property (@(posedge clock) disable iff (!resetn) // RL10
    alu_wb_valid && alu_sets_flags && !alu_op[0]
    |=> program_status_word[CY_BIT] == (($past(alu_a) + $past(alu_b)) < $past(alu_a)))
    else $error("Carry flag wrong after add.");

  // A subtract borrows exactly when the second operand is the larger one.
  AST_CY_BORROW: assert property (@(posedge clock) disable iff (!resetn) // RL10
    alu_wb_valid && alu_sets_flags && alu_op[0]
    |=> program_status_word[CY_BIT] == ($past(alu_b) > $past(alu_a)))
    else $error("Borrow flag wrong after subtract.");

  // Plain operations: overflow when the effective operand signs agree and the
  // result sign differs; the subtract flips the second operand's sign.
  AST_OV_PLAIN: assert property (@(posedge clock) disable iff (!resetn) // RL11
    alu_wb_valid && alu_sets_flags && !alu_op[1]
    |=> program_status_word[OV_BIT] == (($past(alu_a[31]) != alu_result[31])
        && ($past(alu_a[31]) == ($past(alu_b[31]) ^ $past(alu_op[0])))))
    else $error("Overflow flag wrong after plain operation.");

  // In a saturating operation an overflow always leaves saturation set.
  AST_SAT_SET: assert property (@(posedge clock) disable iff (!resetn) // RL6
    alu_wb_valid && alu_sets_flags && alu_op[1]
    |=> !program_status_word[OV_BIT] || program_status_word[SAT_BIT])
    else $error("Saturating overflow left saturation clear.");

  // A write with no competing event lands as the low byte only.
  AST_PSW_WRITE: assert property (@(posedge clock) disable iff (!resetn) // RL1 RL5
    psw_wr_en && !alu_wb_valid && !nmi_ack && !exception_gen && !maskable_irq_grant
    |=> program_status_word == {24'h00_0000, $past(psw_wr_data[7:0])})
    else $error("Status word write did not land.");

  // While an NMI is in service no maskable request gets through.
  AST_NP_BLOCK: assert property (@(posedge clock) disable iff (!resetn) // RL2
    program_status_word[NP_BIT] |-> !maskable_irq_grant)
    else $error("Grant given while NMI in service.");

  // With both blocking flags clear a request is granted in its own cycle.
  AST_GRANT_OPEN: assert property (@(posedge clock) disable iff (!resetn) // RL4
    maskable_irq_req && !program_status_word[ID_BIT] && !program_status_word[NP_BIT]
    |-> maskable_irq_grant)
    else $error("Open request was not granted.");

  // The written-back result only moves on a writeback.
  AST_RESULT_HOLD: assert property (@(posedge clock) disable iff (!resetn) // RL21
    !alu_wb_valid |=> alu_result == $past(alu_result))
    else $error("Result changed without writeback.");

  // An absolute load keeps only the live program counter bits.
  AST_PC_LOAD: assert property (@(posedge clock) disable iff (!resetn) // RL17 RL20
    pc_load_en |=> program_counter == ($past(pc_target) & PC_VALID_MASK))
    else $error("Program counter load not masked.");

endmodule : cpu_status_flags_and_address_wrap

// file: verif/irq_pipe_model.sv
// Purpose: Pipeline-side model that raises interrupt requests and acknowledge events.
// Assumes: It drives on the falling edge and samples grant on the rising edge.
// Notes:   A request is held until grant is seen high or the bound runs out.
`timescale 1ns/100ps
module irq_pipe_model
(
  input  wire logic clock,
  input  wire logic maskable_irq_grant,
  output logic      maskable_irq_req,
  output logic      nmi_ack,
  output logic      exception_gen
);
  ////////////////////////////////////////////////////////////////////////////////
  // All lines start idle so the unit never sees an unknown request.
  initial
  begin
    maskable_irq_req = 1'b0;
    nmi_ack          = 1'b0;
    exception_gen    = 1'b0;
  end

  // Holds the request for at most max_cycles edges; a blocked request gives up.
  task automatic request(input int max_cycles, output logic got);
    got = 1'b0;
    @(negedge clock);
    maskable_irq_req = 1'b1;
    for (int i = 0; i < max_cycles && !got; i++)
    begin
      @(posedge clock);
      got = maskable_irq_grant;
    end
    @(negedge clock);
    maskable_irq_req = 1'b0;
  endtask : request

  // One-cycle event pulse: which low means NMI acknowledge, high means exception.
  task automatic pulse(input logic which);
    @(negedge clock);
    nmi_ack       = !which;
    exception_gen = which;
    @(negedge clock);
    nmi_ack       = 1'b0;
    exception_gen = 1'b0;
  endtask : pulse
endmodule : irq_pipe_model

// file: verif/tb_cpu_status_flags_and_address_wrap.sv
// Purpose: Self-checking bench for the status word and address wrap block.
// Assumes: Every request is taken at one edge and answered by the next edge.
// Notes:   Expected flags are worked out here, independent of the unit.
`timescale 1ns/100ps
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module tb_cpu_status_flags_and_address_wrap;
  import psw_pkg::*;
  logic        clock, resetn, psw_wr_en, alu_wb_valid, alu_sets_flags;   // Bench-driven controls.
  logic        pc_load_en, pc_step_en, opnd_valid, mem_exp_wr_en, mem_exp_enable_in;
  logic        maskable_irq_req, maskable_irq_grant, nmi_ack, exception_gen;
  logic        ext_expansion_en, bus_port_mode, got;
  logic [31:0] psw_wr_data, program_status_word, alu_a, alu_b, alu_result;
  logic [31:0] pc_target, pc_offset, program_counter, opnd_base, opnd_disp, data_addr;
  logic [31:0] exp_psw;                                                  // Predicted status word.
  logic [23:0] data_phys_addr;
  alu_op_t     alu_op;
  int          fail_count   = 0;                                         // Mismatches seen.
  int          total_checks = 0;                                         // Comparisons made.

  cpu_status_flags_and_address_wrap uut (.*);
  irq_pipe_model partner (.clock(clock), .maskable_irq_grant(maskable_irq_grant),
    .maskable_irq_req(maskable_irq_req), .nmi_ack(nmi_ack), .exception_gen(exception_gen));

  ////////////////////////////////////////////////////////////////////////////////
  // The 100 ns core clock.
  always #50 clock = ~clock;

  // Watchdog: a hang counts as a mismatch and goes to the verdict.
  initial
  begin
    repeat (5000) @(posedge clock);
    fail_count++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then stops the run.
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  // Holds reset low for four cycles; also used in mid-run.
  task automatic do_reset();
    resetn = 1'b0;
    repeat (4) @(negedge clock);
    resetn = 1'b1;
    exp_psw = PSW_RESET;
    `CHK(program_status_word, PSW_RESET)
    `CHK(program_counter, RESET_ENTRY_ADDR)
    `CHK(bus_port_mode, 1'b1)
    `CHK(ext_expansion_en, 1'b0)
    $display("test reset done");
  endtask : do_reset

  // Status word write; only the low byte may land.
  task automatic wr_psw(input logic [31:0] d);
    psw_wr_en   = 1'b1;
    psw_wr_data = d;
    @(negedge clock);
    psw_wr_en = 1'b0;
    exp_psw   = {24'h0, d[7:0]};
    `CHK(program_status_word, exp_psw)
    // An idle edge keeps the next call from raising the strobe in this time step.
    @(negedge clock);
  endtask : wr_psw

  // One writeback; flags are predicted from a plain 33-bit sum or difference.
  task automatic alu(input alu_op_t op, input logic [31:0] a, b, input logic setf);
    logic [32:0] raw;
    logic [31:0] res;
    logic        ov;
    raw = op[0] ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
    ov  = (a[31] ^ raw[31]) & (op[0] ? (a[31] ^ b[31]) : ~(a[31] ^ b[31]));
    res = (op[1] && ov) ? (a[31] ? SAT_NEG_MIN : SAT_POS_MAX) : raw[31:0];
    if (setf)
    begin
      exp_psw[3:0] = {raw[32], ov, res[31], res == 32'h0000_0000};
      exp_psw[SAT_BIT] = exp_psw[SAT_BIT] | (op[1] & ov);
    end
    {alu_wb_valid, alu_sets_flags, alu_op, alu_a, alu_b} = {1'b1, setf, op, a, b};
    @(negedge clock);
    alu_wb_valid = 1'b0;
    `CHK(alu_result, res)
    `CHK(program_status_word, exp_psw)
    @(negedge clock);
  endtask : alu

  // Absolute load or relative step of the program counter.
  task automatic pc_op(input logic ld, input logic [31:0] v);
    {pc_load_en, pc_step_en, pc_target, pc_offset} = {ld, !ld, v, v};
    @(negedge clock);
    {pc_load_en, pc_step_en} = 2'b00;
    @(negedge clock);
  endtask : pc_op

  // Operand address calculation, then the expansion enable write.
  task automatic t_addr();
    {opnd_valid, opnd_base, opnd_disp} = {1'b1, 32'hFFFF_FFF0, 32'h0000_0020};
    @(negedge clock);
    `CHK(data_addr, 32'h0000_0010)
    {opnd_base, opnd_disp} = {32'h5A12_3456, 32'h0000_0000};
    @(negedge clock);
    opnd_valid = 1'b0;
    `CHK(data_phys_addr, 24'h12_3456)
    {mem_exp_wr_en, mem_exp_enable_in} = 2'b11;
    @(negedge clock);
    `CHK({ext_expansion_en, bus_port_mode}, 2'b10)
    mem_exp_enable_in = 1'b0;
    @(negedge clock);
    mem_exp_wr_en = 1'b0;
    `CHK({ext_expansion_en, bus_port_mode}, 2'b01)
    $display("test address done");
  endtask : t_addr

  // Status word writes and every arithmetic flag case, saturation included.
  task automatic t_arith();
    wr_psw(32'hFFFF_FFFF);
    wr_psw(32'h0000_0000);
    alu(OP_ADD, 32'hFFFF_FFFF, 32'h0000_0001, 1'b1);
    alu(OP_ADD, 32'h7FFF_FFFF, 32'h0000_0001, 1'b1);
    alu(OP_SUB, 32'h0000_0000, 32'h0000_0001, 1'b1);
    alu(OP_SATADD, SAT_POS_MAX, 32'h0000_0001, 1'b1);
    alu(OP_SATADD, 32'h0000_0002, 32'h0000_0003, 1'b1);
    alu(OP_SATSUB, SAT_NEG_MIN, 32'h0000_0001, 1'b1);
    alu(OP_SUB, 32'h0000_0005, 32'h0000_0005, 1'b0);
    wr_psw(32'h0000_0000);
    alu(OP_SATSUB, 32'hFFFF_FFF0, 32'h0000_0010, 1'b1);
    $display("test arithmetic done");
  endtask : t_arith

  // Interrupt state bits and the maskable grant; result flags are cleared first
  // so the status word holds only the interrupt bits.
  task automatic t_irq();
    wr_psw(32'h0000_0000);
    partner.request(2, got);
    `CHK(got, 1'b1)
    `CHK(program_status_word, 32'h0000_0020)
    partner.request(2, got);
    `CHK(got, 1'b0)
    wr_psw(32'h0000_0000);
    partner.pulse(1'b0);
    `CHK(program_status_word, 32'h0000_0080)
    partner.request(2, got);
    `CHK(got, 1'b0)
    wr_psw(32'h0000_0000);
    partner.pulse(1'b1);
    `CHK(program_status_word, 32'h0000_0040)
    partner.request(2, got);
    `CHK(got, 1'b1)
    `CHK(program_status_word, 32'h0000_0060)
    $display("test interrupts done");
  endtask : t_irq

  // Program counter: upper byte and bit 0 forced low, wrap past bit 23.
  task automatic t_pc();
    pc_op(1'b1, 32'h1234_5679);
    `CHK(program_counter, 32'h0034_5678)
    pc_op(1'b1, 32'h00FF_EFFE);
    pc_op(1'b0, 32'h0000_1004);
    `CHK(program_counter, 32'h0000_0002)
    pc_op(1'b0, 32'hFFFF_FFFE);
    `CHK(program_counter, 32'h0000_0000)
    $display("test program counter done");
  endtask : t_pc

  // Reset in mid-run over live state, then a write at the first edge after release.
  task automatic t_reset_mid();
    wr_psw(32'h0000_0010);
    pc_op(1'b1, 32'h0000_1234);
    do_reset();
    wr_psw(32'h0000_0001);
    $display("test mid reset done");
  endtask : t_reset_mid

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; every input has a value before the first edge.
  initial
  begin
    clock = 1'b0;
    {psw_wr_en, alu_wb_valid, alu_sets_flags, pc_load_en, pc_step_en} = '0;
    {opnd_valid, mem_exp_wr_en, mem_exp_enable_in, alu_op} = '0;
    {psw_wr_data, alu_a, alu_b, pc_target, pc_offset, opnd_base, opnd_disp} = '0;
    do_reset();
    t_arith();
    t_irq();
    t_pc();
    t_addr();
    t_reset_mid();
    results();
  end
endmodule : tb_cpu_status_flags_and_address_wrap
